// File: stm_defs.svh
// Register offsets, field positions and timing constants of the timer
`ifndef STM_DEFS_SVH
`define STM_DEFS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define STM_OFF_CTRL0     12'h000
`define STM_OFF_CTRL1     12'h004
`define STM_OFF_CNT_LO    12'h008
`define STM_OFF_CNT_HI    12'h00c
`define STM_OFF_CMPA_LO   12'h010
`define STM_OFF_CMPA_HI   12'h014
`define STM_OFF_PERIOD    12'h018
`define STM_OFF_FLAGS     12'h01c

// ****************************************************************
// Field positions and values
// ****************************************************************
`define STM_C0_PAUSE      7
`define STM_C0_CK_HI      6
`define STM_C0_CK_LO      4
`define STM_C0_RUN        3
`define STM_C0_MASK       8'hf8
`define STM_C1_MODE_HI    7
`define STM_C1_MODE_LO    6
`define STM_C1_IO_HI      5
`define STM_C1_IO_LO      4
`define STM_C1_OC         3
`define STM_C1_POL        2
`define STM_C1_DPX        1
`define STM_C1_CCLR       0
`define STM_RESET_BYTE    8'h00
`define STM_RESET_WORD    16'h0000
`define STM_ONE_WORD      16'h0001
`define STM_ZERO_BYTE     8'h00
`define STM_FLAG_A        0
`define STM_FLAG_P        1

// ****************************************************************
// Clock divider ratios
// ****************************************************************
`define STM_DIV4_LAST     6'h03
`define STM_DIV16_LAST    6'h0f
`define STM_DIV64_LAST    6'h3f
`define STM_SUB_DIV_LAST  10'h3ff
`define STM_DIV_ZERO      6'h00
`define STM_SUB_ZERO      10'h000

`endif

// File: stm_pkg.sv
// Types shared by the timer files
package stm_pkg;

    typedef enum logic [2:0] {
        STM_CK_SYS4  = 3'h0,
        STM_CK_SYS   = 3'h1,
        STM_CK_HI16  = 3'h2,
        STM_CK_HI64  = 3'h3,
        STM_CK_SUBA  = 3'h4,
        STM_CK_SUBB  = 3'h5,
        STM_CK_EXTR  = 3'h6,
        STM_CK_EXTF  = 3'h7
    } stm_clk_t;

    typedef enum logic [1:0] {
        STM_MODE_CMP = 2'h0,
        STM_MODE_CAP = 2'h1,
        STM_MODE_PWM = 2'h2,
        STM_MODE_TMR = 2'h3
    } stm_mode_t;

    typedef struct packed {
        logic     pause_hold;
        stm_clk_t clock_source_select;
        logic     counter_run;
        logic [2:0] unused;
    } stm_ctrl0_t;

    typedef struct packed {
        stm_mode_t  operating_mode_select;
        logic [1:0] pin_function_select;
        logic       output_initial_level;
        logic       output_invert;
        logic       duty_period_swap;
        logic       clear_source_select;
    } stm_ctrl1_t;

endpackage : stm_pkg

// File: stm_tick.sv
// Clock-enable divider for one prescaled count rate
`timescale 1ns/10ps
module stm_tick #(
    parameter int W = 6
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Control
    input  wire logic [W-1:0] last,
    // Enable pulse
    output logic              tick
);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    wire          wrap = (cnt_r == last);

    assign cnt_nxt = wrap ? '0 : W'(cnt_r + 1'b1);
    assign tick    = wrap;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

endmodule : stm_tick

// File: stm_timer.sv
// Standard 16-bit timer with APB register access
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
`include "stm_defs.svh"

module stm_timer (
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Clock enable from the system
    input  wire logic        high_speed_clock_en,
    // Pins
    input  wire logic        ext_clock_pin,
    input  wire logic        capture_input_pin,
    output logic             waveform_output_pin,
    output logic             waveform_output_en,
    // Status
    output logic             compare_a_flag,
    output logic             compare_p_flag,
    output logic             capture_event
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    stm_pkg::stm_ctrl0_t ctrl0_r;
    stm_pkg::stm_ctrl1_t ctrl1_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [15:0] cmpa_r;
    logic [7:0]  period_r;
    logic [7:0]  lo_buf_r;
    logic [15:0] capture_r;
    logic        flag_a_r;
    logic        flag_p_r;
    logic        run_d_r;
    logic        ext_d_r;
    logic        cap_d_r;
    logic        out_r;
    logic        out_nxt;
    logic        pulse_armed_r;
    logic [9:0]  sub_cnt_r;
    logic [31:0] rdata_nxt;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire acc     = psel & penable;
    wire wr      = acc & pwrite;
    wire rd      = acc & ~pwrite;
    wire hit_c0  = (paddr == `STM_OFF_CTRL0);
    wire hit_c1  = (paddr == `STM_OFF_CTRL1);
    wire hit_dl  = (paddr == `STM_OFF_CNT_LO);
    wire hit_dh  = (paddr == `STM_OFF_CNT_HI);
    wire hit_al  = (paddr == `STM_OFF_CMPA_LO);
    wire hit_ah  = (paddr == `STM_OFF_CMPA_HI);
    wire hit_rp  = (paddr == `STM_OFF_PERIOD);
    wire hit_fl  = (paddr == `STM_OFF_FLAGS);
    wire mapped  = hit_c0 | hit_c1 | hit_dl | hit_dh | hit_al | hit_ah
                 | hit_rp | hit_fl;
    wire [7:0] wbyte = pwdata[7:0];

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // ****************************************************************
    // Count rate
    // ****************************************************************
    logic tick4;
    logic tick16;
    logic tick64;

    stm_tick #(.W(6)) u_div4 (
        .pclk    (pclk),
        .presetn (presetn),
        .last    (`STM_DIV4_LAST),
        .tick    (tick4)
    );

    // High clock divider ticks pass only while its enable is present
    wire hi_tick16 = tick16 & high_speed_clock_en;
    wire hi_tick64 = tick64 & high_speed_clock_en;

    stm_tick #(.W(6)) u_div16 (
        .pclk    (pclk),
        .presetn (presetn),
        .last    (`STM_DIV16_LAST),
        .tick    (tick16)
    );

    stm_tick #(.W(6)) u_div64 (
        .pclk    (pclk),
        .presetn (presetn),
        .last    (`STM_DIV64_LAST),
        .tick    (tick64)
    );

    // Slow clock stands in as a divided system clock
    wire sub_tick = (sub_cnt_r == `STM_SUB_DIV_LAST);
    wire ext_rise = ext_clock_pin & ~ext_d_r;
    wire ext_fall = ~ext_clock_pin & ext_d_r;

    logic rate_tick;
    always_comb
    begin
        case (ctrl0_r.clock_source_select)
            stm_pkg::STM_CK_SYS4: rate_tick = tick4;
            stm_pkg::STM_CK_SYS:  rate_tick = 1'b1;
            stm_pkg::STM_CK_HI16: rate_tick = hi_tick16;
            stm_pkg::STM_CK_HI64: rate_tick = hi_tick64;
            stm_pkg::STM_CK_EXTR: rate_tick = ext_rise;
            stm_pkg::STM_CK_EXTF: rate_tick = ext_fall;
            default:              rate_tick = sub_tick;
        endcase
    end

    // ****************************************************************
    // Comparators and counter
    // ****************************************************************
    stm_pkg::stm_mode_t mode;
    assign mode = ctrl1_r.operating_mode_select;

    wire run_rise = ctrl0_r.counter_run & ~run_d_r;
    wire step     = ctrl0_r.counter_run & ~ctrl0_r.pause_hold
                  & rate_tick;
    wire [15:0] inc = 16'(count_r + `STM_ONE_WORD);

    // Matches judged on the next count so the clear comes with it
    wire p_zero  = (period_r == `STM_ZERO_BYTE);
    wire match_a = step & (inc == cmpa_r);
    wire match_p = step & (p_zero ? (inc == `STM_RESET_WORD)
                                  : (inc[15:8] == period_r)
                                    & (inc[7:0] == `STM_ZERO_BYTE));
    wire is_pwm  = (mode == stm_pkg::STM_MODE_PWM);
    wire is_cap  = (mode == stm_pkg::STM_MODE_CAP);
    wire ccl_a   = ctrl1_r.clear_source_select & ~is_pwm & ~is_cap;
    wire pwm_clr = ctrl1_r.duty_period_swap ? match_a : match_p;
    wire clr     = is_pwm ? pwm_clr
                 : is_cap ? match_p
                 : (ccl_a ? match_a : match_p);

    always_comb
    begin
        if (run_rise)
            count_nxt = `STM_RESET_WORD;
        else if (clr)
            count_nxt = `STM_RESET_WORD;
        else if (step)
            count_nxt = inc;
        else
            count_nxt = count_r;
    end

    // ****************************************************************
    // Output waveform
    // ****************************************************************
    wire [1:0] pfs     = ctrl1_r.pin_function_select;
    wire       oc      = ctrl1_r.output_initial_level;
    wire [15:0] duty_v = ctrl1_r.duty_period_swap
                       ? {period_r, `STM_ZERO_BYTE} : cmpa_r;
    wire       pwm_act = ctrl1_r.duty_period_swap & p_zero
                       ? 1'b1 : (count_r < duty_v);
    wire       cap_r_e = capture_input_pin & ~cap_d_r;
    wire       cap_f_e = ~capture_input_pin & cap_d_r;
    wire       cap_hit = is_cap & ((pfs == 2'h0 & cap_r_e)
                       | (pfs == 2'h1 & cap_f_e)
                       | (pfs == 2'h2 & (cap_r_e | cap_f_e)));

    always_comb
    begin
        out_nxt = out_r;
        case (mode)
            stm_pkg::STM_MODE_CMP:
            begin
                if (run_rise)
                    out_nxt = oc;
                else if (match_a)
                    case (pfs)
                        2'h1:    out_nxt = 1'b0;
                        2'h2:    out_nxt = 1'b1;
                        2'h3:    out_nxt = ~out_r;
                        default: out_nxt = out_r;
                    endcase
            end
            stm_pkg::STM_MODE_PWM:
            begin
                case (pfs)
                    2'h0:    out_nxt = ~oc;
                    2'h1:    out_nxt = oc;
                    2'h2:    out_nxt = pwm_act ? oc : ~oc;
                    default: out_nxt = (pulse_armed_r & ctrl0_r.counter_run
                                        & pwm_act) ? oc : ~oc;
                endcase
            end
            default: out_nxt = out_r;
        endcase
    end

    assign waveform_output_pin = out_r ^ ctrl1_r.output_invert;
    assign waveform_output_en  = ctrl0_r.counter_run
                               & (mode != stm_pkg::STM_MODE_TMR)
                               & ~is_cap;
    assign compare_a_flag = flag_a_r;
    assign compare_p_flag = flag_p_r;
    assign capture_event  = cap_hit;

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (hit_c0)
            rdata_nxt[7:0] = ctrl0_r & `STM_C0_MASK;
        else if (hit_c1)
            rdata_nxt[7:0] = ctrl1_r;
        else if (hit_dl | hit_al)
            rdata_nxt[7:0] = lo_buf_r;
        else if (hit_dh)
            rdata_nxt[7:0] = is_cap ? capture_r[15:8] : count_r[15:8];
        else if (hit_ah)
            rdata_nxt[7:0] = cmpa_r[15:8];
        else if (hit_rp)
            rdata_nxt[7:0] = period_r;
        else if (hit_fl)
            rdata_nxt[1:0] = {flag_p_r, flag_a_r};
    end
    assign prdata = rdata_nxt;

    // ****************************************************************
    // State
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl0_r  <= stm_pkg::stm_ctrl0_t'(`STM_RESET_BYTE);
            ctrl1_r  <= stm_pkg::stm_ctrl1_t'(`STM_RESET_BYTE);
            period_r <= `STM_RESET_BYTE;
            cmpa_r   <= `STM_RESET_WORD;
        end
        else if (wr)
        begin
            if (hit_c0)
                ctrl0_r <= stm_pkg::stm_ctrl0_t'(wbyte & `STM_C0_MASK);
            if (hit_c1)
                ctrl1_r <= stm_pkg::stm_ctrl1_t'(wbyte);
            if (hit_rp)
                period_r <= wbyte;
            if (hit_ah)
                cmpa_r <= {wbyte, lo_buf_r};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lo_buf_r <= `STM_RESET_BYTE;
        else if (wr & hit_al)
            lo_buf_r <= wbyte;
        else if (rd & hit_dh)
            lo_buf_r <= is_cap ? capture_r[7:0] : count_r[7:0];
        else if (rd & hit_ah)
            lo_buf_r <= cmpa_r[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_r       <= `STM_RESET_WORD;
            capture_r     <= `STM_RESET_WORD;
            run_d_r       <= 1'b0;
            ext_d_r       <= 1'b0;
            cap_d_r       <= 1'b0;
            out_r         <= 1'b0;
            pulse_armed_r <= 1'b0;
            sub_cnt_r     <= `STM_SUB_ZERO;
        end
        else
        begin
            count_r   <= count_nxt;
            run_d_r   <= ctrl0_r.counter_run;
            ext_d_r   <= ext_clock_pin;
            cap_d_r   <= capture_input_pin;
            out_r     <= out_nxt;
            sub_cnt_r <= 10'(sub_cnt_r + 1'b1);
            if (cap_hit)
                capture_r <= count_r;
            if (run_rise)
                pulse_armed_r <= 1'b1;
            else if (pfs == 2'h3 & pwm_clr)
                pulse_armed_r <= 1'b0;
        end
    end

    // Hardware set wins over a software clear in the same cycle
    wire set_a = match_a;
    wire set_p = match_p & ~(ccl_a & ~is_pwm);
    wire clr_a = wr & hit_fl & wbyte[`STM_FLAG_A];
    wire clr_p = wr & hit_fl & wbyte[`STM_FLAG_P];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_a_r <= 1'b0;
            flag_p_r <= 1'b0;
        end
        else
        begin
            flag_a_r <= set_a | (flag_a_r & ~clr_a);
            flag_p_r <= set_p | (flag_p_r & ~clr_p);
        end
    end

endmodule : stm_timer

// File: stm_timer_checker.sv
// Port-level assertions for the timer
`timescale 1ns/10ps
module stm_timer_checker (
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pin and status
    input wire logic        waveform_output_pin,
    input wire logic        waveform_output_en,
    input wire logic        compare_a_flag,
    input wire logic        compare_p_flag,
    input wire logic        capture_event
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****************
    // Control shadows
    // ****************
    logic [7:0] c0_r;
    logic [7:0] c1_r;
    wire        acc = psel && penable && pready;
    wire        wr0 = acc && pwrite && paddr == 12'h000;
    wire        wr1 = acc && pwrite && paddr == 12'h004;
    wire        run = c0_r[3];
    wire [1:0]  mode = c1_r[7:6];
    // Clear source only matters in compare and timer modes
    wire        clr_a = c1_r[0] && mode[1] == mode[0];
    wire        go = run && !c0_r[7];
    wire        forced = run && mode == 2'h2 && !c1_r[5];
    wire [7:0]  c0_nxt = wr0 ? pwdata[7:0] : c0_r;
    wire [7:0]  c1_nxt = wr1 ? pwdata[7:0] : c1_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            c0_r <= 8'h00;
            c1_r <= 8'h00;
        end
        else
        begin
            c0_r <= c0_nxt;
            c1_r <= c1_nxt;
        end
    end
    sequence run_rise;
        wr0 && pwdata[3] && !run;
    endsequence
    sequence held;
        forced && $stable(c1_r);
    endsequence
    // ****************
    // Properties
    // ****************
    AST_PIN_EN:
        assert property (waveform_output_en == (run && !mode[0]))
        else $error("pin enable disagrees with mode");
    AST_CTRL0_LOW:
        assert property (acc && !pwrite && paddr == 12'h000 |->
            prdata[2:0] == 3'h0 && prdata[31:8] == 24'h0)
        else $error("unused control bits read nonzero");
    // Start edge is seen one cycle late, the pin follows one cycle later
    AST_INIT_LEVEL:
        assert property (run_rise |=> ##1 (mode != 2'h0 ||
            waveform_output_pin == (c1_r[3] ^ c1_r[2])))
        else $error("pin not at initial level after start");
    AST_CAP_MODE:
        assert property (capture_event |->
            mode == 2'h1 && c1_r[5:4] != 2'h3)
        else $error("capture outside enabled capture mode");
    AST_P_FLAG:
        assert property ($rose(compare_p_flag) |-> !$past(clr_a))
        else $error("P flag raised while A clears");
    AST_A_FLAG:
        assert property ($rose(compare_a_flag) |-> $past(go))
        else $error("A flag raised while halted");
    AST_FORCED:
        assert property (held [*3] |-> waveform_output_pin ==
            (~(c1_r[4] ^ c1_r[3]) ^ c1_r[2]))
        else $error("forced level wrong");
    AST_SLVERR:
        assert property (acc && paddr[1:0] == 2'h0 |->
            pslverr == (paddr > 12'h01c))
        else $error("error response wrong");
endmodule : stm_timer_checker
bind stm_timer stm_timer_checker i_stm_timer_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .waveform_output_pin(waveform_output_pin),
    .waveform_output_en(waveform_output_en),
    .compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag),
    .capture_event(capture_event)
);

// File: stm_pin_model.sv
// Pin-side model: external count clock and capture input
`timescale 1ns/10ps
module stm_pin_model (
    // Clock
    input  wire logic       pclk,
    // Requests
    input  wire logic       start,
    input  wire logic [9:0] pulses,
    input  wire logic       cap_start,
    // Pins
    output logic            ext_clock_pin,
    output logic            capture_input_pin,
    output logic            busy
);
    // Quarter steps left; pins stand low between bursts
    logic [11:0] left_r = 12'h000;
    logic [2:0]  cap_r = 3'h0;
    wire [11:0]  left_nxt = left_r == 12'h000 ? left_r : left_r - 12'h001;
    wire [2:0]   cap_nxt = cap_r == 3'h0 ? cap_r : cap_r - 3'h1;
    always @(posedge pclk)
    begin
        left_r <= start ? {pulses, 2'b00} : left_nxt;
        cap_r <= cap_start ? 3'h7 : cap_nxt;
    end
    // Two cycles high, two low, so a sampled edge is never missed
    assign ext_clock_pin = left_r[1];
    assign capture_input_pin = cap_r[2];
    assign busy = left_r != 12'h000 || cap_r != 3'h0;
endmodule : stm_pin_model

// File: stm_timer_bench.sv
// Self-checking bench for the timer
`timescale 1ns/10ps
module stm_timer_bench;
    logic        pclk, presetn, psel, penable, pwrite, hs_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, ext_pin, cap_pin, pin, pin_en;
    logic        flag_a, flag_p, cap_ev, start, cap_start, busy;
    logic [9:0]  pulses;
    logic [32:0] expq[$];
    logic [7:0]  pwm_c1[4] = '{8'h88, 8'h94, 8'ha9, 8'hab};
    int          failures, checks, seed, k, cap_cnt;
    stm_timer i_stm_timer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .high_speed_clock_en(hs_en),
        .ext_clock_pin(ext_pin), .capture_input_pin(cap_pin),
        .waveform_output_pin(pin), .waveform_output_en(pin_en),
        .compare_a_flag(flag_a), .compare_p_flag(flag_p),
        .capture_event(cap_ev));
    stm_pin_model i_stm_pin_model (
        .pclk(pclk), .start(start), .pulses(pulses), .cap_start(cap_start),
        .ext_clock_pin(ext_pin), .capture_input_pin(cap_pin), .busy(busy));
    // ****************
    // Tasks
    // ****************
    task automatic print_verdict;
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            failures++;
            print_verdict();
        end
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [7:0] e,
                      input logic err);
        expq.push_back({err, 24'h0, e});
        apb(1'b0, a, 8'h00);
    endtask : rd
    task automatic rcnt(input logic [15:0] e);
        rd(12'h00c, e[15:8], 1'b0);
        rd(12'h008, e[7:0], 1'b0);
    endtask : rcnt
    // Bursts are waited out so the counter is still when read
    task automatic pulse(input int n, input logic cap);
        int t;
        @(posedge pclk);
        start <= 1'b1;
        cap_start <= cap;
        pulses <= 10'(n);
        @(posedge pclk);
        start <= 1'b0;
        cap_start <= 1'b0;
        t = 0;
        do
        begin
            @(negedge pclk);
            t++;
        end
        while (busy !== 1'b0 && t < 5000);
        repeat (4) @(negedge pclk);
        if (t >= 5000)
        begin
            failures++;
            print_verdict();
        end
    endtask : pulse
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite && expq.size() > 0)
            chk({pslverr, prdata}, expq.pop_front());
    always @(posedge pclk)
        if (cap_ev === 1'b1)
            cap_cnt++;
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ****************
    // Main sequence
    // ****************
    initial
    begin
        {presetn, psel, penable, pwrite, start, cap_start} = 6'h00;
        {paddr, pwdata, pulses} = '0;
        {hs_en, failures, checks, seed, cap_cnt} = {1'b1, 32'd0, 32'd0,
                                                    32'd62, 32'd0};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(12'(4 * i), 8'h00, 1'b0);
        rd(12'h020, 8'h00, 1'b1);
        apb(1'b1, 12'h000, 8'hf7);
        rd(12'h000, 8'hf0, 1'b0);
        apb(1'b1, 12'h000, 8'h00);
        k = $random(seed);
        apb(1'b1, 12'h004, k[7:0]);
        rd(12'h004, k[7:0], 1'b0);
        apb(1'b1, 12'h010, k[15:8]);
        rd(12'h010, k[15:8], 1'b0);
        rd(12'h014, 8'h00, 1'b0);
        // The high read above refilled the buffer, so load it again
        apb(1'b1, 12'h010, k[15:8]);
        apb(1'b1, 12'h014, k[23:16]);
        rd(12'h014, k[23:16], 1'b0);
        rd(12'h010, k[15:8], 1'b0);
        apb(1'b1, 12'h018, k[31:24]);
        rd(12'h018, k[31:24], 1'b0);
        apb(1'b1, 12'h00c, 8'hff);
        rcnt(16'h0000);
        // Timer mode counting external edges, overflow clear
        apb(1'b1, 12'h018, 8'h00);
        apb(1'b1, 12'h004, 8'hc0);
        apb(1'b1, 12'h000, 8'h68);
        k = {$random(seed)} % 8 + 1;
        pulse(k, 1'b0);
        rcnt(16'(k));
        apb(1'b1, 12'h000, 8'he8);
        pulse(3, 1'b0);
        rcnt(16'(k));
        apb(1'b1, 12'h000, 8'h78);
        pulse(2, 1'b0);
        rcnt(16'(k + 2));
        apb(1'b1, 12'h000, 8'h70);
        pulse(2, 1'b0);
        rcnt(16'(k + 2));
        apb(1'b1, 12'h018, 8'h01);
        apb(1'b1, 12'h000, 8'h68);
        rcnt(16'h0000);
        pulse(255, 1'b0);
        chk(flag_p, 1'b0);
        pulse(1, 1'b0);
        chk(flag_p, 1'b1);
        rcnt(16'h0000);
        // A clears at 288; the P match at 256 neither clears nor flags
        apb(1'b1, 12'h000, 8'h60);
        apb(1'b1, 12'h004, 8'hc1);
        apb(1'b1, 12'h010, 8'h20);
        apb(1'b1, 12'h014, 8'h01);
        apb(1'b1, 12'h01c, 8'h03);
        apb(1'b1, 12'h000, 8'h68);
        pulse(300, 1'b0);
        rcnt(16'h000c);
        chk({flag_a, flag_p}, 2'b10);
        apb(1'b1, 12'h010, 8'h10);
        apb(1'b1, 12'h014, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, 12'h000, 8'h60);
            apb(1'b1, 12'h004, {2'b00, i[2:1], i[0], i[1], 2'b01});
            apb(1'b1, 12'h000, 8'h68);
            repeat (2) @(negedge pclk);
            chk(pin, i[0] ^ i[1]);
            pulse(16, 1'b0);
            k = i[2:1] == 2'b00 ? i[0] : i[2:1] == 2'b11 ? !i[0] : i[2];
            chk(pin, k[0] ^ i[1]);
        end
        apb(1'b1, 12'h010, 8'h40);
        apb(1'b1, 12'h014, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, 12'h000, 8'h60);
            apb(1'b1, 12'h004, pwm_c1[i]);
            apb(1'b1, 12'h000, 8'h68);
            pulse(80, 1'b0);
            chk(pin, i[0]);
            rcnt(i == 3 ? 16'h0010 : 16'h0050);
        end
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, 12'h000, 8'h10);
            apb(1'b1, 12'h004, {2'b01, i[1:0], 4'h0});
            apb(1'b1, 12'h000, 8'h18);
            cap_cnt = 0;
            pulse(0, 1'b1);
            chk(cap_cnt, i == 3 ? 0 : i == 2 ? 2 : 1);
        end
        // High clock rate must not count while its enable is absent
        apb(1'b1, 12'h000, 8'h20);
        hs_en <= 1'b0;
        apb(1'b1, 12'h004, 8'hc0);
        apb(1'b1, 12'h000, 8'h28);
        repeat (40) @(posedge pclk);
        rcnt(16'h0000);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h004, 8'h00, 1'b0);
        repeat (3) @(posedge pclk);
        print_verdict();
    end
endmodule : stm_timer_bench
